/* File: common/fsp_regs.svh */
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// ****************************************
// Configuration indices
// ****************************************
`define FSP_IDX_MISC 8'h03
`define FSP_IDX_SETUP 8'h05
`define FSP_IDX_DRV_TYPE 8'h06
`define FSP_IDX_PWR 8'h07

// ****************************************
// Reset values
// ****************************************
`define FSP_SETUP_RST 8'h00
`define FSP_DRV_TYPE_RST 8'hff
`define FSP_PWR_RST 8'h00
`define FSP_FORCE_HIGH_RST 1'b1

// ****************************************
// Writable and hard-reset bit masks
// ****************************************
`define FSP_SETUP_WMASK 8'h3f
`define FSP_DRV_TYPE_WMASK 8'hff
`define FSP_PWR_WMASK 8'hff
`define FSP_PWR_HARD_MASK 8'hfc

// ****************************************
// Field positions
// ****************************************
`define FSP_SETUP_PUSH_PULL 0
`define FSP_SETUP_TRISTATE 1
`define FSP_SETUP_NON_BURST 2
`define FSP_SETUP_DEN_LO 3
`define FSP_SETUP_DEN_HI 4
`define FSP_SETUP_SWAP 5
`define FSP_MISC_FORCE_HIGH 4
`define FSP_PWR_BOOT_LO 0
`define FSP_PWR_BOOT_HI 1
`define FSP_PWR_UART3 2
`define FSP_PWR_UART4 3
`define FSP_PWR_UART2 5
`define FSP_PWR_UART1 6
`define FSP_PWR_FLOPPY 7

// ****************************************
// Pin counts
// ****************************************
`define FSP_FDD_PINS 8

`endif

/* File: common/fsp_pkg.sv */
package fsp_pkg;

  // ****************************************
  // Density select override codes
  // ****************************************
  typedef enum logic [1:0] {
    FSP_DEN_NORMAL = 2'b00,
    FSP_DEN_RSVD = 2'b01,
    FSP_DEN_ONE = 2'b10,
    FSP_DEN_ZERO = 2'b11
  } fsp_den_t;

  // ****************************************
  // Register bank state
  // ****************************************
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] drv_type;
    logic [7:0] pwr;
    logic force_high;
    logic [7:0] rdata;
    logic rd_valid;
    logic den_sel;
    logic [1:0] pp_drive_sel;
    logic [1:0] pp_motor_sel;
  } fsp_bank_t;

  // ****************************************
  // Pad driver state
  // ****************************************
  typedef struct packed {
    logic o;
    logic oe;
  } fsp_pad_t;

endpackage : fsp_pkg

/* File: design/fsp_pad.sv */
`timescale 1ns/1ps

module fsp_pad
  import fsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic val,
  input wire logic push_pull,
  input wire logic tristate,
  output logic pin_o,
  output logic pin_oe
);

  fsp_pad_t st;
  fsp_pad_t next_st;

  // ****************************************
  // Driver style selection
  // ****************************************

  // Open drain only pulls low; a high level relies on the pull-up
  always_comb
  begin
    next_st = '0;
    if (tristate)
    begin
      next_st.o = 1'b0;
      next_st.oe = 1'b0;
    end
    else if (push_pull)
    begin
      next_st.o = val;
      next_st.oe = 1'b1;
    end
    else
    begin
      next_st.o = 1'b0;
      next_st.oe = ~val;
    end
  end

  // Released pad until reset ends
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_o = st.o;
  assign pin_oe = st.oe;

endmodule : fsp_pad

/* File: design/fsp_config_bank.sv */
`timescale 1ns/1ps
`include "fsp_regs.svh"

module fsp_config_bank
  import fsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hard_rst_n,
  input wire logic cfg_mode,
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rd_valid,
  output logic cfg_hit,
  input wire logic [`FSP_FDD_PINS-1:0] fdd_func,
  output logic [`FSP_FDD_PINS-1:0] fdd_pin_o,
  output logic [`FSP_FDD_PINS-1:0] fdd_pin_oe,
  input wire logic density_one_func,
  output logic density_one_pin_o,
  output logic density_one_pin_oe,
  input wire logic density_select_func,
  output logic density_select_output,
  input wire logic [1:0] pp_drive_sel_in,
  input wire logic [1:0] pp_motor_sel_in,
  output logic [1:0] pp_drive_sel,
  output logic [1:0] pp_motor_sel,
  output logic dma_non_burst,
  output logic [7:0] drive_type_ids,
  output logic [1:0] boot_drive,
  output logic uart1_auto_pd,
  output logic uart2_auto_pd,
  output logic uart3_auto_pd,
  output logic uart4_auto_pd,
  output logic floppy_auto_pd
);

  // ****************************************
  // Index decode
  // ****************************************

  // Any access outside the configuration state is not ours
  function automatic logic sel(input logic mode, input logic [7:0] idx,
                               input logic [7:0] target);
    sel = mode && (idx == target);
  endfunction : sel

  fsp_bank_t st;
  fsp_bank_t next_st;
  logic hit_misc;
  logic hit_setup;
  logic hit_drv;
  logic hit_pwr;
  logic push_pull;
  logic tristate;
  logic dens_val;
  fsp_den_t den_mode;

  // Decoded selects, each gated by the config state
  assign hit_misc = sel(cfg_mode, cfg_index, `FSP_IDX_MISC);
  assign hit_setup = sel(cfg_mode, cfg_index, `FSP_IDX_SETUP);
  assign hit_drv = sel(cfg_mode, cfg_index, `FSP_IDX_DRV_TYPE);
  assign hit_pwr = sel(cfg_mode, cfg_index, `FSP_IDX_PWR);
  assign cfg_hit = hit_misc | hit_setup | hit_drv | hit_pwr;

  // ****************************************
  // Setup field decode
  // ****************************************

  // Output driver controls for the native floppy pins and the density-one pin
  assign push_pull = st.setup[`FSP_SETUP_PUSH_PULL];
  assign tristate = st.setup[`FSP_SETUP_TRISTATE];
  assign den_mode = fsp_den_t'(st.setup[`FSP_SETUP_DEN_HI:`FSP_SETUP_DEN_LO]);

  // Forced high beats the function value; tristate handled in the pad
  assign dens_val = st.force_high | density_one_func;

  // ****************************************
  // Next state
  // ****************************************

  // Reserved bits are masked on write so they always stay zero
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    if (cfg_wr && hit_misc)
      next_st.force_high = cfg_wdata[`FSP_MISC_FORCE_HIGH];
    if (cfg_wr && hit_setup)
      next_st.setup = cfg_wdata & `FSP_SETUP_WMASK;
    if (cfg_wr && hit_drv)
      next_st.drv_type = cfg_wdata & `FSP_DRV_TYPE_WMASK;
    if (cfg_wr && hit_pwr)
      next_st.pwr = cfg_wdata & `FSP_PWR_WMASK;
    // Read data is held until the next read
    if (cfg_rd)
    begin
      next_st.rd_valid = 1'b1;
      if (hit_misc)
        next_st.rdata = 8'(st.force_high) << `FSP_MISC_FORCE_HIGH;
      else if (hit_setup)
        next_st.rdata = st.setup & `FSP_SETUP_WMASK;
      else if (hit_drv)
        next_st.rdata = st.drv_type;
      else if (hit_pwr)
        next_st.rdata = st.pwr;
      else
        next_st.rdata = 8'h00;
    end
    // Reserved code 01 falls back to normal density selection
    unique case (den_mode)
      FSP_DEN_ONE: next_st.den_sel = 1'b1;
      FSP_DEN_ZERO: next_st.den_sel = 1'b0;
      FSP_DEN_NORMAL,
      FSP_DEN_RSVD: next_st.den_sel = density_select_func;
    endcase
    // Parallel-port floppy path: swap only, no driver-style control
    if (st.setup[`FSP_SETUP_SWAP])
    begin
      next_st.pp_drive_sel = {pp_drive_sel_in[0], pp_drive_sel_in[1]};
      next_st.pp_motor_sel = {pp_motor_sel_in[0], pp_motor_sel_in[1]};
    end
    else
    begin
      next_st.pp_drive_sel = pp_drive_sel_in;
      next_st.pp_motor_sel = pp_motor_sel_in;
    end
    // Hard reset clears the powerdown enables but keeps the boot drive;
    // applied last so it beats a same-cycle write for bits 7:2 only
    if (!hard_rst_n)
      next_st.pwr = next_st.pwr & ~`FSP_PWR_HARD_MASK;
  end

  // ****************************************
  // State register
  // ****************************************

  // Power-on reset sets every field to its documented default
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.setup <= `FSP_SETUP_RST;
      st.drv_type <= `FSP_DRV_TYPE_RST;
      st.pwr <= `FSP_PWR_RST;
      st.force_high <= `FSP_FORCE_HIGH_RST;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // Floppy pin drivers
  // ****************************************

  // One pad per native floppy output
  // Pads lag a setup write by one clock; software cannot see the gap
  genvar gi;
  generate
    for (gi = 0; gi < `FSP_FDD_PINS; gi++)
    begin : g_pad
      fsp_pad u_pad (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .val(fdd_func[gi]),
        .push_pull(push_pull),
        .tristate(tristate),
        .pin_o(fdd_pin_o[gi]),
        .pin_oe(fdd_pin_oe[gi])
      );
    end
  endgenerate

  // Density-one pin shares the native driver controls
  fsp_pad u_dens_pad (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .val(dens_val),
    .push_pull(push_pull),
    .tristate(tristate),
    .pin_o(density_one_pin_o),
    .pin_oe(density_one_pin_oe)
  );

  // ****************************************
  // Outputs
  // ****************************************

  // All data outputs come straight from state flip-flops
  assign cfg_rdata = st.rdata;
  assign cfg_rd_valid = st.rd_valid;
  assign density_select_output = st.den_sel;
  assign pp_drive_sel = st.pp_drive_sel;
  assign pp_motor_sel = st.pp_motor_sel;
  assign dma_non_burst = st.setup[`FSP_SETUP_NON_BURST];
  assign drive_type_ids = st.drv_type;
  assign boot_drive = st.pwr[`FSP_PWR_BOOT_HI:`FSP_PWR_BOOT_LO];
  assign uart3_auto_pd = st.pwr[`FSP_PWR_UART3];
  assign uart4_auto_pd = st.pwr[`FSP_PWR_UART4];
  assign uart2_auto_pd = st.pwr[`FSP_PWR_UART2];
  assign uart1_auto_pd = st.pwr[`FSP_PWR_UART1];
  assign floppy_auto_pd = st.pwr[`FSP_PWR_FLOPPY];

endmodule : fsp_config_bank

/* File: tb/fsp_config_bank_props.sv */
`timescale 1ns/1ps
// ****************
// Bank port checks
// ****************
module fsp_config_bank_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hard_rst_n,
  input wire logic cfg_mode,
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rd_valid,
  input wire logic cfg_hit,
  input wire logic [7:0] fdd_pin_oe,
  input wire logic [7:0] drive_type_ids,
  input wire logic [1:0] boot_drive,
  input wire logic floppy_auto_pd,
  input wire logic uart3_auto_pd
);
  // One domain, so clock and reset are shared
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  hit_decode_a: assert property (cfg_hit == (cfg_mode &&
    cfg_index inside {8'h03, 8'h05, 8'h06, 8'h07}))
    else $error("index decode wrong");
  rd_valid_pulse_a: assert property (cfg_rd |=> cfg_rd_valid)
    else $error("read valid missing");
  refused_read_a: assert property (cfg_rd && !cfg_hit |=>
    cfg_rdata == 8'h00) else $error("refused read not zero");
  refused_wr_a: assert property (cfg_wr && !cfg_hit |=>
    $stable(drive_type_ids)) else $error("refused write landed");
  setup_ro_read_a: assert property (cfg_rd && cfg_hit &&
    cfg_index == 8'h05 |=> cfg_rdata[7:6] == 2'b00)
    else $error("setup top bits not zero");
  // Pads lag the register by one cycle
  tristate_pins_a: assert property (cfg_wr && cfg_hit &&
    cfg_index == 8'h05 && cfg_wdata[1] ##1 !(cfg_wr && cfg_index
    == 8'h05) |=> fdd_pin_oe == 8'h00) else $error("pins driven");
  drive_type_wr_a: assert property (cfg_wr && cfg_hit &&
    cfg_index == 8'h06 |=> drive_type_ids == $past(cfg_wdata))
    else $error("drive type write lost");
  pwr_write_a: assert property (cfg_wr && cfg_hit &&
    cfg_index == 8'h07 && hard_rst_n |=> boot_drive ==
    $past(cfg_wdata[1:0]) && floppy_auto_pd == $past(cfg_wdata[7]))
    else $error("power write lost");
  hard_rst_pd_a: assert property (!hard_rst_n |=>
    !floppy_auto_pd && !uart3_auto_pd) else $error("pd not cleared");
  hard_keep_boot_a: assert property (!hard_rst_n && !cfg_wr |=>
    $stable(boot_drive)) else $error("boot lost on hard reset");
  hard_wr_boot_a: assert property (cfg_wr && cfg_hit &&
    cfg_index == 8'h07 && !hard_rst_n |=> boot_drive ==
    $past(cfg_wdata[1:0]) && !floppy_auto_pd)
    else $error("hard reset write wrong");
endmodule : fsp_config_bank_props

bind fsp_config_bank fsp_config_bank_props fsp_config_bank_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .hard_rst_n(hard_rst_n),
  .cfg_mode(cfg_mode), .cfg_index(cfg_index), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cfg_rd_valid(cfg_rd_valid), .cfg_hit(cfg_hit),
  .fdd_pin_oe(fdd_pin_oe), .drive_type_ids(drive_type_ids),
  .boot_drive(boot_drive), .floppy_auto_pd(floppy_auto_pd),
  .uart3_auto_pd(uart3_auto_pd));

/* File: tb/fsp_config_bank_tb_top.sv */
`timescale 1ns/1ps
// ****************
// Bank testbench
// ****************
module fsp_config_bank_tb_top;
  logic clk_sys, rst_n, hard_rst_n, cfg_mode, cfg_wr, cfg_rd;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata, fdd_func, fdd_pin_o;
  logic [7:0] fdd_pin_oe, drive_type_ids;
  logic cfg_rd_valid, cfg_hit, den_func, den_o, den_oe, dma_nb, ds_func;
  logic [1:0] drv_in, mot_in, drv_sel, mot_sel, boot_drive;
  logic [4:0] pd;
  logic ds_out;
  int bad_count, check_count, cycles;

  fsp_config_bank fsp_config_bank_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .hard_rst_n(hard_rst_n),
    .cfg_mode(cfg_mode), .cfg_index(cfg_index), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .cfg_hit(cfg_hit),
    .fdd_func(fdd_func), .fdd_pin_o(fdd_pin_o), .fdd_pin_oe(fdd_pin_oe),
    .density_one_func(den_func), .density_one_pin_o(den_o),
    .density_one_pin_oe(den_oe), .density_select_func(ds_func),
    .density_select_output(ds_out), .pp_drive_sel_in(drv_in),
    .pp_motor_sel_in(mot_in), .pp_drive_sel(drv_sel),
    .pp_motor_sel(mot_sel), .dma_non_burst(dma_nb),
    .drive_type_ids(drive_type_ids), .boot_drive(boot_drive),
    .uart1_auto_pd(pd[3]), .uart2_auto_pd(pd[2]),
    .uart3_auto_pd(pd[0]), .uart4_auto_pd(pd[1]),
    .floppy_auto_pd(pd[4]));

  // Free running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Waits two more cycles so pads settle
  task automatic wr(input logic [7:0] idx, dat);
    @(negedge clk_sys);
    cfg_index = idx;
    cfg_wdata = dat;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] idx, exp, input string what);
    @(negedge clk_sys);
    cfg_index = idx;
    cfg_rd = 1'b1;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    chk(8'(cfg_rd_valid), 8'h01, "read valid");
    chk(cfg_rdata, exp, what);
  endtask : rd

  task automatic t_reset;
    rd(8'h05, 8'h00, "setup");
    rd(8'h06, 8'hff, "drive type");
    rd(8'h07, 8'h00, "power");
    rd(8'h03, 8'h10, "misc");
    chk(8'(den_oe), 8'h00, "density oe");
    chk(fdd_pin_oe, 8'h5a, "open drain oe");
    $display("reset test done");
  endtask : t_reset

  task automatic t_setup;
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h3f, "setup ro");
    chk(8'(dma_nb), 8'h01, "non burst");
    chk(fdd_pin_oe, 8'h00, "tristate oe");
    chk(8'(den_oe), 8'h00, "density tristate");
    wr(8'h05, 8'h01);
    chk(fdd_pin_o, 8'ha5, "push pull o");
    chk(fdd_pin_oe, 8'hff, "push pull oe");
    den_func = 1'b0;
    wr(8'h03, 8'h00);
    chk(8'(den_o), 8'h00, "density normal");
    wr(8'h03, 8'h10);
    chk(8'(den_o), 8'h01, "density forced");
    wr(8'h05, 8'h00);
    chk(8'(dma_nb), 8'h00, "burst");
    ds_func = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(8'(ds_out), 8'h01, "density select normal");
    ds_func = 1'b0;
    wr(8'h05, 8'h08);
    chk(8'(ds_out), 8'h00, "density select reserved");
    wr(8'h05, 8'h10);
    chk(8'(ds_out), 8'h01, "density select one");
    ds_func = 1'b1;
    wr(8'h05, 8'h18);
    chk(8'(ds_out), 8'h00, "density select zero");
    wr(8'h05, 8'h00);
    $display("setup test done");
  endtask : t_setup

  task automatic t_swap;
    drv_in = 2'b01;
    mot_in = 2'b10;
    wr(8'h05, 8'h22);
    chk(8'({drv_sel, mot_sel}), 8'h09, "swapped");
    wr(8'h05, 8'h00);
    chk(8'({drv_sel, mot_sel}), 8'h06, "unswapped");
    $display("swap test done");
  endtask : t_swap

  task automatic t_pwr;
    wr(8'h06, 8'h1b);
    chk(drive_type_ids, 8'h1b, "drive type");
    wr(8'h07, 8'h5a);
    chk(8'(boot_drive), 8'h02, "boot other");
    chk(8'(pd), 8'h0a, "auto pd other");
    wr(8'h07, 8'ha5);
    chk(8'(boot_drive), 8'h01, "boot");
    chk(8'(pd), 8'h15, "auto pd");
    @(negedge clk_sys);
    hard_rst_n = 1'b0;
    @(negedge clk_sys);
    hard_rst_n = 1'b1;
    rd(8'h07, 8'h01, "power hard");
    chk(8'(pd), 8'h00, "pd hard");
    // Write and hard reset in one cycle: boot bits take the write
    @(negedge clk_sys);
    cfg_index = 8'h07;
    cfg_wdata = 8'hff;
    cfg_wr = 1'b1;
    hard_rst_n = 1'b0;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    hard_rst_n = 1'b1;
    rd(8'h07, 8'h03, "power hard write");
    $display("power test done");
  endtask : t_pwr

  task automatic t_refuse;
    cfg_mode = 1'b0;
    wr(8'h06, 8'h00);
    chk(drive_type_ids, 8'h1b, "no mode write");
    rd(8'h06, 8'h00, "no mode read");
    cfg_mode = 1'b1;
    wr(8'h04, 8'h55);
    chk(8'(cfg_hit), 8'h00, "hit");
    rd(8'h04, 8'h00, "other index");
    rd(8'h06, 8'h1b, "kept");
    $display("refuse test done");
  endtask : t_refuse

  // Mid-run power-on reset restores every default
  task automatic t_por;
    wr(8'h05, 8'h3f);
    wr(8'h03, 8'h00);
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(8'h05, 8'h00, "setup por");
    rd(8'h06, 8'hff, "drive type por");
    rd(8'h07, 8'h00, "power por");
    rd(8'h03, 8'h10, "misc por");
    chk(fdd_pin_oe, 8'h5a, "open drain oe por");
    $display("power-on reset test done");
  endtask : t_por

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Hang guard, far above the roughly 130 cycles used
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // Main sequence
  initial
  begin
    {rst_n, hard_rst_n, cfg_wr, cfg_rd, den_func, ds_func} = '0;
    {cfg_index, cfg_wdata, drv_in, mot_in} = '0;
    cfg_mode = 1'b1;
    fdd_func = 8'ha5;
    hard_rst_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_setup();
    t_swap();
    t_pwr();
    t_refuse();
    t_por();
    report_and_stop();
  end
endmodule : fsp_config_bank_tb_top
